// ==== hdl/blt_pkg.sv ====
// Purpose: Shared constants for the brightness slope and boost target block
// Assumes: 25 MHz mclk, register port at byte offsets
// Notes: Reset values of both control registers are zero
package blt_pkg;
    // Register map
    localparam logic [7:0] RAMP_CTRL_OFS = 8'h15;
    localparam logic [7:0] BOOST_CTRL_OFS = 8'h16;
    localparam logic [7:0] RAMP_CTRL_RST = 8'h00;
    localparam logic [7:0] BOOST_CTRL_RST = 8'h00;
    localparam logic [7:0] UNMAPPED_RD = 8'h00;
    // Field positions
    localparam int FILTER_STRENGTH_SEL_LSB = 6;
    localparam int DEADBAND_LSB = 3;
    localparam int RAMP_LSB = 0;
    localparam int CEIL_LSB = 6;
    localparam int TRACK_BIT = 5;
    localparam int START_LSB = 0;
    // Timing
    localparam int CLK_NS = 40;
    localparam int UNIT_NS = 3906;
    localparam int UNIT_CYC = UNIT_NS / CLK_NS;
    localparam int HEADROOM_TRACKING_EN_NS = 100000;
    localparam int HEADROOM_TRACKING_EN_CYC = HEADROOM_TRACKING_EN_NS / CLK_NS;
    localparam int SAMP_NUM = 4;
    localparam int SAMP_DEN = 5;
    localparam int RAMP_STEPS = 256;
    localparam int STEP_FRAC = 8;
    localparam int DUTY_W = 12;
    localparam int MEAS_W = 17;
    localparam logic [16:0] MEAS_SAT = 17'h1ffff;
    localparam logic [11:0] DUTY_FULL = 12'hfff;
    localparam logic [3:0] DIV_LAST = 4'hb;
    // Ceiling codes: highest start code not above each limit
    localparam logic [4:0] CEIL_18V = 5'h10;
    localparam logic [4:0] CEIL_22V = 5'h16;
    localparam logic [4:0] CEIL_25V = 5'h1a;
    localparam logic [4:0] CEIL_28V = 5'h1f;
    // States
    typedef enum logic {RAMP_IDLE = 1'b0, RAMP_RUN = 1'b1} blt_ramp_e;
    typedef enum logic {MEAS_IDLE = 1'b0, MEAS_DIV = 1'b1} blt_meas_e;
endpackage : blt_pkg

// ==== hdl/blt_iir.sv ====
// Purpose: First-order low-pass on the ramped level
// Assumes: step_en is a one-cycle enable
// Notes: Shift of zero passes the input straight through
module blt_iir (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Filter control
    input wire logic step_en,
    input wire logic [3:0] shift,
    // Data
    input wire logic [19:0] level_in,
    output logic [11:0] level_out
);
    logic [19:0] y, next_y;
    logic [19:0] diff, inc;

    always_comb begin
        next_y = y;
        diff = (level_in >= y) ? level_in - y : y - level_in;
        inc = diff >> shift;
        // Never stall short of the input
        if (inc == 20'h0 && diff != 20'h0) begin
            inc = 20'h1;
        end
        if (step_en) begin
            next_y = (level_in >= y) ? y + inc : y - inc;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            y <= 20'h0;
        end else begin
            y <= next_y;
        end
    end

    assign level_out = y[19:8];
endmodule : blt_iir

// ==== hdl/blt_duty_meas.sv ====
// Purpose: PWM input duty detector with serial divider
// Assumes: samp_en pulses at the 20 MHz sampling rate
// Notes: One duty result per input period, or per timeout if static
module blt_duty_meas (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Sampling
    input wire logic samp_en,
    input wire logic pwm_in,
    // Result
    output logic [11:0] duty,
    output logic duty_valid
);
    blt_pkg::blt_meas_e state, next_state;
    logic pwm_prev, next_pwm_prev, armed, next_armed;
    logic [16:0] per_cnt, next_per_cnt, high_cnt, next_high_cnt;
    logic [16:0] den, next_den;
    logic [17:0] rem, next_rem, rem2;
    logic [11:0] quo, next_quo, next_duty;
    logic [3:0] bit_cnt, next_bit_cnt;
    logic next_duty_valid, rise, start_div;

    always_comb begin
        next_state = state;
        next_pwm_prev = pwm_prev;
        next_armed = armed;
        next_per_cnt = per_cnt;
        next_high_cnt = high_cnt;
        next_den = den;
        next_rem = rem;
        next_quo = quo;
        next_bit_cnt = bit_cnt;
        next_duty = duty;
        next_duty_valid = 1'b0;
        rise = samp_en && pwm_in && !pwm_prev;
        start_div = rise && armed && state == blt_pkg::MEAS_IDLE;
        rem2 = {rem[16:0], 1'b0};
        if (samp_en) begin
            next_pwm_prev = pwm_in;
            if (rise) begin
                next_armed = 1'b1;
                next_per_cnt = 17'h1;
                next_high_cnt = 17'h1;
            end else if (per_cnt == blt_pkg::MEAS_SAT) begin
                // Static input: report 0 or full scale
                next_duty = pwm_in ? blt_pkg::DUTY_FULL : 12'h000;
                next_duty_valid = 1'b1;
                next_armed = 1'b0;
                next_per_cnt = 17'h0;
                next_high_cnt = 17'h0;
            end else begin
                next_per_cnt = per_cnt + 17'h1;
                next_high_cnt = high_cnt + {16'h0, pwm_in};
            end
        end
        case (state)
            blt_pkg::MEAS_IDLE: begin
                if (start_div) begin
                    next_den = per_cnt;
                    next_rem = {1'b0, high_cnt};
                    next_quo = 12'h000;
                    next_bit_cnt = 4'h0;
                    if (high_cnt >= per_cnt) begin
                        next_duty = blt_pkg::DUTY_FULL;
                        next_duty_valid = 1'b1;
                    end else begin
                        next_state = blt_pkg::MEAS_DIV;
                    end
                end
            end
            blt_pkg::MEAS_DIV: begin
                // Fraction high/period, one quotient bit per cycle
                if (rem2 >= {1'b0, den}) begin
                    next_rem = rem2 - {1'b0, den};
                    next_quo = {quo[10:0], 1'b1};
                end else begin
                    next_rem = rem2;
                    next_quo = {quo[10:0], 1'b0};
                end
                next_bit_cnt = bit_cnt + 4'h1;
                if (bit_cnt == blt_pkg::DIV_LAST) begin
                    next_duty = next_quo;
                    next_duty_valid = 1'b1;
                    next_state = blt_pkg::MEAS_IDLE;
                end
            end
            default: next_state = blt_pkg::MEAS_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state <= blt_pkg::MEAS_IDLE;
            pwm_prev <= 1'b0;
            armed <= 1'b0;
            per_cnt <= 17'h0;
            high_cnt <= 17'h0;
            den <= 17'h0;
            rem <= 18'h0;
            quo <= 12'h000;
            bit_cnt <= 4'h0;
            duty <= 12'h000;
            duty_valid <= 1'b0;
        end else begin
            state <= next_state;
            pwm_prev <= next_pwm_prev;
            armed <= next_armed;
            per_cnt <= next_per_cnt;
            high_cnt <= next_high_cnt;
            den <= next_den;
            rem <= next_rem;
            quo <= next_quo;
            bit_cnt <= next_bit_cnt;
            duty <= next_duty;
            duty_valid <= next_duty_valid;
        end
    end

    AST_DIV_LATENCY: assert property (@(posedge mclk) disable iff (!rst_b)
        (start_div && high_cnt < per_cnt) |-> ##13 duty_valid)
        else $error("duty result late or missing");
endmodule : blt_duty_meas

// ==== hdl/blt_core.sv ====
// Purpose: Brightness slope, smoothing, PWM duty intake and boost A target
// Assumes: Register port single-cycle, inputs synchronous to mclk
// Notes: Read data appears the cycle after reg_rd_en
// Functional notes
// - Two-bit smoothing strength, none to heavy
// - Three-bit ramp code selects ramp time
// - Ramp time independent of level difference
// - Smoothing acts like RC, scales with ramp
// - Combined ramp time follows code pair
// - Duty measured by 20 MHz oversampling
// - Duty at most 12 bits precision
// - Accept duty only beyond hysteresis
// - Hysteresis codes: none, 1 to 64 steps
// - Two-bit ceiling selects 18 to 28 V
// - Boost target never above ceiling
// - Tracking off holds start code
// - Tracking on varies between 7 V and ceiling
// - Five-bit start code, 7 to 28 V
module blt_core (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd_en,
    output logic [7:0] reg_rdata,
    // PWM brightness input
    input wire logic pwm_in,
    // Current sink headroom feedback
    input wire logic headroom_low,
    input wire logic headroom_high,
    // Results
    output logic [11:0] duty_level,
    output logic [11:0] brightness,
    output logic ramp_busy,
    output logic [4:0] boost_target_code
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    function automatic logic [7:0] ramp_units(input logic [2:0] code);
        case (code)
            3'h1: ramp_units = 8'd8;
            3'h2: ramp_units = 8'd16;
            3'h3: ramp_units = 8'd24;
            3'h4: ramp_units = 8'd28;
            3'h5: ramp_units = 8'd32;
            3'h6: ramp_units = 8'd100;
            3'h7: ramp_units = 8'd200;
            default: ramp_units = 8'd1;
        endcase
    endfunction : ramp_units

    function automatic logic [12:0] deadband(input logic [2:0] code);
        deadband = (code == 3'h0) ? 13'h0 : 13'h1 << (code - 3'h1);
    endfunction : deadband

    function automatic logic [4:0] ceil_code(input logic [1:0] sel);
        case (sel)
            2'h0: ceil_code = blt_pkg::CEIL_18V;
            2'h1: ceil_code = blt_pkg::CEIL_22V;
            2'h2: ceil_code = blt_pkg::CEIL_25V;
            default: ceil_code = blt_pkg::CEIL_28V;
        endcase
    endfunction : ceil_code

    // Register file
    logic [7:0] ramp_ctrl, next_ramp_ctrl, boost_ctrl, next_boost_ctrl, next_reg_rdata;
    logic ramp_wr;

    always_comb begin
        next_ramp_ctrl = ramp_ctrl;
        next_boost_ctrl = boost_ctrl;
        next_reg_rdata = reg_rdata;
        ramp_wr = reg_wr_en && reg_addr == blt_pkg::RAMP_CTRL_OFS;
        if (ramp_wr) begin
            next_ramp_ctrl = reg_wdata;
        end else if (reg_wr_en && reg_addr == blt_pkg::BOOST_CTRL_OFS) begin
            next_boost_ctrl = reg_wdata;
        end
        if (reg_rd_en) begin
            if (reg_addr == blt_pkg::RAMP_CTRL_OFS) begin
                next_reg_rdata = ramp_ctrl;
            end else if (reg_addr == blt_pkg::BOOST_CTRL_OFS) begin
                next_reg_rdata = boost_ctrl;
            end else begin
                next_reg_rdata = blt_pkg::UNMAPPED_RD;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ramp_ctrl <= blt_pkg::RAMP_CTRL_RST;
            boost_ctrl <= blt_pkg::BOOST_CTRL_RST;
            reg_rdata <= 8'h00;
        end else begin
            ramp_ctrl <= next_ramp_ctrl;
            boost_ctrl <= next_boost_ctrl;
            reg_rdata <= next_reg_rdata;
        end
    end

    logic [1:0] filter_strength_sel, boost_ceiling_sel;
    logic [2:0] duty_change_deadband, ramp_code;
    logic headroom_tracking_en;
    logic [4:0] boost_start_code;
    assign filter_strength_sel = ramp_ctrl[blt_pkg::FILTER_STRENGTH_SEL_LSB +: 2];
    assign duty_change_deadband = ramp_ctrl[blt_pkg::DEADBAND_LSB +: 3];
    assign ramp_code = ramp_ctrl[blt_pkg::RAMP_LSB +: 3];
    assign boost_ceiling_sel = boost_ctrl[blt_pkg::CEIL_LSB +: 2];
    assign headroom_tracking_en = boost_ctrl[blt_pkg::TRACK_BIT];
    assign boost_start_code = boost_ctrl[blt_pkg::START_LSB +: 5];

    // 20 MHz sample enable: four pulses in every five clocks
    logic [2:0] samp_acc, next_samp_acc;
    logic samp_en, next_samp_en;

    always_comb begin
        if (samp_acc >= 3'(blt_pkg::SAMP_DEN - blt_pkg::SAMP_NUM)) begin
            next_samp_acc = samp_acc - 3'(blt_pkg::SAMP_DEN - blt_pkg::SAMP_NUM);
            next_samp_en = 1'b1;
        end else begin
            next_samp_acc = samp_acc + 3'(blt_pkg::SAMP_NUM);
            next_samp_en = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            // Start at the top so the first pulse group is a full four
            samp_acc <= 3'(blt_pkg::SAMP_NUM);
            samp_en <= 1'b0;
        end else begin
            samp_acc <= next_samp_acc;
            samp_en <= next_samp_en;
        end
    end

    // Duty intake with change hysteresis
    logic [11:0] new_duty, next_duty_level;
    logic new_valid, accept, acc_pulse;
    logic [12:0] duty_diff;

    blt_duty_meas u_meas (
        .mclk(mclk),
        .rst_b(rst_b),
        .samp_en(samp_en),
        .pwm_in(pwm_in),
        .duty(new_duty),
        .duty_valid(new_valid)
    );

    always_comb begin
        duty_diff = (new_duty >= duty_level) ? {1'b0, new_duty - duty_level}
                                             : {1'b0, duty_level - new_duty};
        accept = new_valid && duty_diff > deadband(duty_change_deadband);
        next_duty_level = accept ? new_duty : duty_level;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            duty_level <= 12'h000;
            acc_pulse <= 1'b0;
        end else begin
            duty_level <= next_duty_level;
            acc_pulse <= accept;
        end
    end

    // Step timebase: 1/256 ms units, step every ramp_units of them
    logic [6:0] unit_cnt, next_unit_cnt;
    logic [7:0] ms_cnt, next_ms_cnt, units;
    logic unit_tick, step_tick;

    always_comb begin
        units = ramp_units(ramp_code);
        unit_tick = unit_cnt == 7'(blt_pkg::UNIT_CYC - 1);
        step_tick = unit_tick && ms_cnt >= units - 8'd1;
        next_unit_cnt = unit_tick ? 7'h0 : unit_cnt + 7'h1;
        next_ms_cnt = ms_cnt;
        if (step_tick) begin
            next_ms_cnt = 8'h0;
        end else if (unit_tick) begin
            next_ms_cnt = ms_cnt + 8'h1;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            unit_cnt <= 7'h0;
            ms_cnt <= 8'h0;
        end else begin
            unit_cnt <= next_unit_cnt;
            ms_cnt <= next_ms_cnt;
        end
    end

    // Linear ramp: fixed 256 steps, so duration never depends on distance
    blt_pkg::blt_ramp_e ramp_state, next_ramp_state;
    logic [19:0] level_fx, next_level_fx, ramp_mag, next_ramp_mag, target_fx;
    logic ramp_up, next_ramp_up;
    logic [7:0] step_cnt, next_step_cnt;

    always_comb begin
        next_ramp_state = ramp_state;
        next_level_fx = level_fx;
        next_ramp_mag = ramp_mag;
        next_ramp_up = ramp_up;
        next_step_cnt = step_cnt;
        target_fx = {duty_level, 8'h00};
        case (ramp_state)
            blt_pkg::RAMP_IDLE: begin
                if (acc_pulse && ramp_code == 3'h0) begin
                    next_level_fx = target_fx;
                end else if (acc_pulse) begin
                    next_ramp_state = blt_pkg::RAMP_RUN;
                end
            end
            blt_pkg::RAMP_RUN: begin
                if (step_tick) begin
                    next_step_cnt = step_cnt + 8'h1;
                    if (step_cnt == 8'(blt_pkg::RAMP_STEPS - 1)) begin
                        next_level_fx = target_fx;
                        next_ramp_state = blt_pkg::RAMP_IDLE;
                    end else begin
                        // Truncated increment never overshoots the target
                        next_level_fx = ramp_up ? level_fx + (ramp_mag >> blt_pkg::STEP_FRAC)
                                                : level_fx - (ramp_mag >> blt_pkg::STEP_FRAC);
                    end
                end
            end
            default: next_ramp_state = blt_pkg::RAMP_IDLE;
        endcase
        // New target restarts from the present level
        if (acc_pulse && ramp_code != 3'h0) begin
            next_ramp_up = target_fx >= level_fx;
            next_ramp_mag = (target_fx >= level_fx) ? target_fx - level_fx : level_fx - target_fx;
            next_step_cnt = 8'h0;
            next_level_fx = level_fx;
            next_ramp_state = blt_pkg::RAMP_RUN;
        end else if (acc_pulse) begin
            next_level_fx = target_fx;
            next_ramp_state = blt_pkg::RAMP_IDLE;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ramp_state <= blt_pkg::RAMP_IDLE;
            level_fx <= 20'h0;
            ramp_mag <= 20'h0;
            ramp_up <= 1'b0;
            step_cnt <= 8'h0;
            ramp_busy <= 1'b0;
        end else begin
            ramp_state <= next_ramp_state;
            level_fx <= next_level_fx;
            ramp_mag <= next_ramp_mag;
            ramp_up <= next_ramp_up;
            step_cnt <= next_step_cnt;
            ramp_busy <= next_ramp_state == blt_pkg::RAMP_RUN;
        end
    end

    // Smoothing coefficient per code pair; filter steps with the ramp clock
    logic [3:0] filt_shift;
    always_comb begin
        if (filter_strength_sel == 2'h0) begin
            filt_shift = 4'h0;
        end else if (ramp_code == 3'h0) begin
            filt_shift = {2'h0, filter_strength_sel} + 4'h6;
        end else begin
            filt_shift = {2'h0, filter_strength_sel} + 4'h4;
        end
    end

    blt_iir u_iir (
        .mclk(mclk),
        .rst_b(rst_b),
        .step_en(step_tick),
        .shift(filt_shift),
        .level_in(level_fx),
        .level_out(brightness)
    );

    // Boost A target: fixed start code, or tracking within 0 and ceiling
    logic [11:0] headroom_tracking_en_cnt, next_headroom_tracking_en_cnt;
    logic [4:0] next_boost, ceil;
    logic headroom_tracking_en_tick;

    always_comb begin
        ceil = ceil_code(boost_ceiling_sel);
        headroom_tracking_en_tick = headroom_tracking_en_cnt == 12'(blt_pkg::HEADROOM_TRACKING_EN_CYC - 1);
        next_headroom_tracking_en_cnt = headroom_tracking_en_tick ? 12'h0 : headroom_tracking_en_cnt + 12'h1;
        next_boost = boost_target_code;
        if (!headroom_tracking_en) begin
            next_boost = (boost_start_code < ceil) ? boost_start_code : ceil;
        end else begin
            if (headroom_tracking_en_tick && headroom_low && boost_target_code < ceil) begin
                next_boost = boost_target_code + 5'h1;
            end else if (headroom_tracking_en_tick && headroom_high && boost_target_code != 5'h0) begin
                next_boost = boost_target_code - 5'h1;
            end
            if (next_boost > ceil) begin
                next_boost = ceil;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            headroom_tracking_en_cnt <= 12'h0;
            boost_target_code <= 5'h0;
        end else begin
            headroom_tracking_en_cnt <= next_headroom_tracking_en_cnt;
            boost_target_code <= next_boost;
        end
    end

    // Step period check helpers
    logic [14:0] gap_cnt, ramp_cyc;
    logic same_cfg;
    assign ramp_cyc = 15'(units * 15'(blt_pkg::UNIT_CYC)) - 15'h1;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            gap_cnt <= 15'h0;
            same_cfg <= 1'b0;
        end else begin
            gap_cnt <= step_tick ? 15'h0 : gap_cnt + 15'h1;
            same_cfg <= ramp_wr ? 1'b0 : (step_tick | same_cfg);
        end
    end

    AST_SAMP_RATE: assert property (!samp_en |=> samp_en [*4] ##1 !samp_en)
        else $error("sample enable not four of five");
    AST_STEP_PERIOD: assert property ((step_tick && same_cfg && !ramp_wr) |-> gap_cnt == ramp_cyc)
        else $error("ramp step period wrong");
    AST_RAMP_END: assert property ((ramp_state == blt_pkg::RAMP_RUN && step_tick
        && !acc_pulse && step_cnt == 8'hff) |=> level_fx == {$past(duty_level), 8'h00})
        else $error("ramp missed target at last step");
    AST_RAMP_IMMED: assert property ((acc_pulse && ramp_code == 3'h0)
        |=> level_fx == {$past(duty_level), 8'h00})
        else $error("zero ramp code not immediate");
    AST_HOLD: assert property ((new_valid && duty_diff <= deadband(duty_change_deadband))
        |=> $stable(duty_level))
        else $error("duty changed inside hysteresis");
    AST_ACCEPT: assert property ((new_valid && duty_diff > deadband(duty_change_deadband))
        |=> duty_level == $past(new_duty) && acc_pulse)
        else $error("duty beyond hysteresis not accepted");
    AST_NO_FILTER_STRENGTH_SEL: assert property ((step_tick && filter_strength_sel == 2'h0)
        |=> brightness == $past(level_fx[19:8]))
        else $error("unsmoothed output differs from ramp");
    AST_CEIL: assert property (1'b1 |=> boost_target_code <= ceil_code($past(boost_ceiling_sel)))
        else $error("boost target above ceiling");
    AST_FIXED: assert property (!headroom_tracking_en |=> boost_target_code ==
        (($past(boost_start_code) < $past(ceil)) ? $past(boost_start_code) : $past(ceil)))
        else $error("boost target not held at start code");
endmodule : blt_core

// ==== dv/blt_host_pwm.sv ====
// Purpose: Host model driving the PWM brightness input
// Assumes: Period and high time are counted in mclk cycles
// Notes: Output moves on the falling edge only
module blt_host_pwm (
    // Clock
    input wire logic mclk,
    // Waveform
    input wire logic [15:0] period,
    input wire logic [15:0] high,
    output logic pwm_in = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] cnt = 16'h0000;
    // 20 kHz keeps the divider gap and still gives 10-bit resolution
    always @(negedge mclk) begin
        cnt <= (cnt + 16'h0001 >= period) ? 16'h0000 : cnt + 16'h0001;
        pwm_in <= cnt < high;
    end
endmodule : blt_host_pwm

// ==== dv/test_brightness_slope_and_boost_target.sv ====
// Purpose: Register, boost target and PWM duty tests
// Assumes: Host model provides the PWM waveform
// Notes: Ramp code 0 used for the duty checks so the run stays short
module test_brightness_slope_and_boost_target;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr_en = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_rd_en = 1'b0;
    logic [7:0] reg_rdata;
    logic pwm_in;
    logic headroom_low = 1'b0;
    logic headroom_high = 1'b0;
    logic [11:0] duty_level;
    logic [11:0] brightness;
    logic ramp_busy;
    logic [4:0] boost_target_code;
    logic [15:0] high = 16'h0000;
    logic [11:0] kept;
    logic [4:0] ceil_tab [4] = '{5'h10, 5'h16, 5'h1a, 5'h1f};
    int n_errors = 0;
    int tests_run = 0;
    always #20 mclk = ~mclk;
    blt_core dut (.mclk, .rst_b, .reg_addr, .reg_wr_en, .reg_wdata, .reg_rd_en,
        .reg_rdata, .pwm_in, .headroom_low, .headroom_high, .duty_level,
        .brightness, .ramp_busy, .boost_target_code);
    blt_host_pwm host (.mclk, .period(16'h04e2), .high, .pwm_in);
    task automatic close_out();
        $display("tests %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : close_out
    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr_en = 1'b1;
        @(negedge mclk);
        reg_wr_en = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(negedge mclk);
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(negedge mclk);
        reg_rd_en = 1'b0;
        @(negedge mclk);
        chk(what, {4'h0, exp}, {4'h0, reg_rdata});
    endtask : rd
    // Bounded wait for an accepted duty inside a window
    task automatic wait_duty(input logic [11:0] lo, input logic [11:0] hi, input string what);
        int i;
        for (i = 0; i < 20000 && !(duty_level >= lo && duty_level <= hi); i++)
            @(negedge mclk);
        tests_run++;
        if (i == 20000) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, lo, duty_level);
            close_out();
        end
    endtask : wait_duty
    initial begin
        repeat (12) @(negedge mclk);
        rst_b = 1'b1;
        rd(blt_pkg::RAMP_CTRL_OFS, blt_pkg::RAMP_CTRL_RST, "ramp reset");
        rd(blt_pkg::BOOST_CTRL_OFS, blt_pkg::BOOST_CTRL_RST, "boost reset");
        wr(8'h15, 8'hf9);
        rd(8'h15, 8'hf9, "ramp readback");
        wr(8'h20, 8'h5a);
        rd(8'h20, blt_pkg::UNMAPPED_RD, "unmapped");
        $display("test registers done");
        for (int c = 0; c < 4; c++) begin
            wr(8'h16, {c[1:0], 6'h1f});
            repeat (2) @(negedge mclk);
            chk("ceiling", {7'h00, ceil_tab[c]}, {7'h00, boost_target_code});
            wr(8'h16, {c[1:0], 6'h11});
            repeat (2) @(negedge mclk);
            kept = {7'h00, (ceil_tab[c] < 5'h11) ? ceil_tab[c] : 5'h11};
            chk("start", kept, {7'h00, boost_target_code});
        end
        $display("test boost fixed done");
        // Tracking can never go below the 7 V code nor above the ceiling
        wr(8'h16, 8'h01);
        wr(8'h16, 8'h20);
        headroom_high = 1'b1;
        repeat (2600) @(negedge mclk);
        chk("track floor", 12'h000, {7'h00, boost_target_code});
        headroom_high = 1'b0;
        headroom_low = 1'b1;
        repeat (45000) @(negedge mclk);
        chk("track ceiling", 12'h010, {7'h00, boost_target_code});
        headroom_low = 1'b0;
        $display("test boost tracking done");
        wr(8'h15, 8'h38);
        high = 16'h0139;
        wait_duty(12'h3fc, 12'h408, "duty quarter");
        // Filter only moves on a step tick, up to 97 cycles apart
        repeat (110) @(negedge mclk);
        chk("brightness", duty_level, brightness);
        kept = duty_level;
        high = 16'h014a;
        repeat (6000) @(negedge mclk);
        chk("deadband hold", kept, duty_level);
        high = 16'h0271;
        wait_duty(12'h7fc, 12'h804, "duty half");
        wr(8'h15, 8'h00);
        high = 16'h014a;
        wait_duty(12'h434, 12'h43e, "no deadband");
        // Sixteen steps would be held by the old deadband
        high = 16'h014f;
        wait_duty(12'h447, 12'h44b, "small step");
        $display("test duty done");
        wr(8'h15, 8'h01);
        high = 16'h0271;
        wait_duty(12'h7fc, 12'h804, "duty ramp");
        repeat (2) @(negedge mclk);
        chk("ramp busy", 12'h001, {11'h000, ramp_busy});
        $display("test ramp done");
        close_out();
    end
endmodule : test_brightness_slope_and_boost_target
